// ---- rtl/isx_exec.sv ----
// Execute stage for increment-skip-if-zero and or-literal-into-accumulator.
// Assumes the fetch unit holds I_INSN stable for a whole instruction cycle
// and the register file answers I_FILE_RDATA in the cycle after O_FILE_RE.
//
// Overview of operation
// - Increment-skip is word 00_1111_d_fffffff, d selects destination, f the 7-bit address.
// - Increment-skip adds one to the register, writes the accumulator if d=0 or the register if d=1, flags unchanged.
// - A zero increment result turns the next instruction into a no-op, making two cycles; otherwise one.
// - Increment-skip decodes in phase one, reads in two, captures the operand in three, computes and writes in four.
// - Or-literal is word 11_1000_kkkkkkkk with an 8-bit literal.
// - Or-literal ORs the literal into the accumulator and updates the zero flag from the result.
// - Or-literal takes one cycle: decodes in phase one, captures the literal in three, computes and writes the accumulator in four.
// - The zero flag (status bit 2) is set on a zero result and cleared on a nonzero one.
`timescale 1ns/10ps
module isx_exec (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic [13:0] I_INSN,
   input wire logic [7:0] I_FILE_RDATA,
   output logic [3:0] O_PHASE,
   output logic O_FILE_RE,
   output logic [6:0] O_FILE_ADDR,
   output logic O_FILE_WE,
   output logic [7:0] O_FILE_WDATA,
   output logic [7:0] O_ACC,
   output logic O_ZERO,
   output logic O_SKIP,
   output logic O_CYCLE_END
);
   // ----------------------------------------
   // Phase and decode
   // ----------------------------------------
   isx_pkg::isx_phase_t phase;
   logic is_inc_r, is_or_r, dest_r, skip_r, skip_nxt;
   logic [6:0] addr_r;
   logic [7:0] lit_r, opnd_r, res_r, acc_r;
   logic zero_r;

   isx_phase_gen u_phase (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .o_phase(phase)
   );

   // Latch decode in phase one; a skipped slot decodes as nothing
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         is_inc_r <= 1'b0;
         is_or_r <= 1'b0;
         dest_r <= 1'b0;
         addr_r <= 7'h00;
         lit_r <= 8'h00;
      end else if (phase == isx_pkg::ISX_PH_FIRST) begin
         is_inc_r <= !skip_r && I_INSN[isx_pkg::CLS_HI:isx_pkg::CLS_LO] == isx_pkg::CLS_FILE
                     && I_INSN[isx_pkg::OP_HI:isx_pkg::OP_LO] == isx_pkg::OP_INC_SKIP;
         is_or_r <= !skip_r && I_INSN[isx_pkg::CLS_HI:isx_pkg::CLS_LO] == isx_pkg::CLS_LIT
                    && I_INSN[isx_pkg::OP_HI:isx_pkg::OP_LO] == isx_pkg::OP_OR_LIT;
         dest_r <= I_INSN[isx_pkg::DEST_BIT];
         addr_r <= I_INSN[isx_pkg::ADDR_W-1:0];
         lit_r <= I_INSN[isx_pkg::DATA_W-1:0];
      end
   end

   // ----------------------------------------
   // Operand read (phase two)
   // ----------------------------------------
   // Register file is strobed in phase two and answers by phase three
   assign O_FILE_RE = (phase == isx_pkg::ISX_PH_SECOND) && is_inc_r;
   assign O_FILE_ADDR = addr_r;

   // Capture operand at phase three: register data or the literal
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         opnd_r <= 8'h00;
      end else if (phase == isx_pkg::ISX_PH_THIRD) begin
         opnd_r <= is_inc_r ? I_FILE_RDATA : lit_r;
      end
   end

   // ----------------------------------------
   // Process (phase four)
   // ----------------------------------------
   // Result is formed in phase four from the captured operand
   always_comb begin
      res_r = 8'h00;
      if (is_inc_r) begin
         res_r = opnd_r + 8'h01;
      end else if (is_or_r) begin
         res_r = acc_r | opnd_r;
      end
   end

   // ----------------------------------------
   // Write back (phase four)
   // ----------------------------------------
   // Accumulator: or-literal always, increment only when d is 0
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         acc_r <= isx_pkg::ACC_RST;
      end else if (phase == isx_pkg::ISX_PH_FOURTH && (is_or_r || (is_inc_r && !dest_r))) begin
         acc_r <= res_r;
      end
   end

   // Zero flag touched only by or-literal; increment leaves flags alone
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         zero_r <= isx_pkg::ZERO_RST;
      end else if (phase == isx_pkg::ISX_PH_FOURTH && is_or_r) begin
         zero_r <= (res_r == 8'h00);
      end
   end

   // File write is a phase-four strobe for d=1
   assign O_FILE_WE = (phase == isx_pkg::ISX_PH_FOURTH) && is_inc_r && dest_r;
   assign O_FILE_WDATA = res_r;

   // ----------------------------------------
   // Skip control
   // ----------------------------------------
   // Arm skip at phase four on a zero increment; one skip slot only,
   // so a skipped increment can never chain a second skip
   assign skip_nxt = is_inc_r && (res_r == 8'h00);
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         skip_r <= 1'b0;
      end else if (phase == isx_pkg::ISX_PH_FOURTH) begin
         skip_r <= skip_nxt;
      end
   end

   assign O_PHASE = phase;
   assign O_ACC = acc_r;
   assign O_ZERO = zero_r;
   assign O_SKIP = skip_r;
   assign O_CYCLE_END = (phase == isx_pkg::ISX_PH_FOURTH);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Read strobe sits in phase two, so the write lands two clocks later
   read_phase_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_FILE_RE |-> phase == isx_pkg::ISX_PH_SECOND ##2 phase == isx_pkg::ISX_PH_FOURTH)
      else $error("file read outside phase two");
   write_phase_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_FILE_WE |-> phase == isx_pkg::ISX_PH_FOURTH && O_FILE_WDATA == opnd_r + 8'h01)
      else $error("file write wrong phase or value");
   inc_acc_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_inc_r && !dest_r) |=> O_ACC == $past(opnd_r) + 8'h01)
      else $error("increment did not reach accumulator");
   inc_flags_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_inc_r) |=> $stable(O_ZERO))
      else $error("increment changed zero flag");
   skip_arm_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_inc_r) |=> O_SKIP == ($past(res_r) == 8'h00))
      else $error("skip not armed from zero result");
   skip_slot_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_SKIP && phase == isx_pkg::ISX_PH_FIRST) |=> !is_inc_r && !is_or_r && !O_FILE_RE ##2 !O_FILE_WE)
      else $error("skipped slot executed");
   or_result_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_or_r) |=> O_ACC == ($past(acc_r) | $past(opnd_r)))
      else $error("or-literal result wrong");
   or_lit_phase_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (phase == isx_pkg::ISX_PH_THIRD && is_or_r) |=> opnd_r == $past(lit_r) && O_CYCLE_END)
      else $error("literal not taken in phase three");
   zero_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_or_r) |=> O_ZERO == (O_ACC == 8'h00))
      else $error("zero flag disagrees with result");
   decode_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (phase == isx_pkg::ISX_PH_FIRST && !O_SKIP && I_INSN[13:8] == 6'h0F) |=> is_inc_r && addr_r == $past(I_INSN[6:0]))
      else $error("increment-skip not decoded");
   or_decode_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (phase == isx_pkg::ISX_PH_FIRST && !O_SKIP && I_INSN[13:8] == 6'h38) |=> is_or_r)
      else $error("or-literal not decoded");

   // ----------------------------------------
   // Sequencer and side-effect checks
   // ----------------------------------------
   // A stuck or doubled phase bit would silently stretch the instruction cycle
   phase_onehot_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $onehot(phase))
      else $error("phase not one-hot");

   // Every instruction is exactly four clocks, phase four wraps to one
   phase_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      phase == isx_pkg::ISX_PH_FOURTH |=> phase == isx_pkg::ISX_PH_FIRST)
      else $error("phase did not wrap");

   // Or-literal works on the accumulator alone; the register file stays quiet
   or_no_file_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      is_or_r |-> !O_FILE_RE && !O_FILE_WE)
      else $error("or-literal touched register file");

   // With d set the result goes to the register, never the accumulator
   inc_to_reg_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && is_inc_r && dest_r) |=> $stable(O_ACC))
      else $error("register increment changed accumulator");

   // The discarded slot keeps skip high for its whole four clocks
   skip_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_SKIP && phase == isx_pkg::ISX_PH_FIRST) |-> ##3 O_SKIP)
      else $error("skip dropped inside slot");

   // Only one slot is discarded; the no-op slot cannot rearm it
   skip_once_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_SKIP && O_CYCLE_END) |=> !O_SKIP)
      else $error("skip lasted more than one slot");

   // Zero flag moves only on or-literal; other slots leave it alone
   zero_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && !is_or_r) |=> $stable(O_ZERO))
      else $error("zero flag changed without logic result");

   // Undecoded words are no-ops and must leave the accumulator unchanged
   acc_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (O_CYCLE_END && !is_or_r && !is_inc_r) |=> $stable(O_ACC))
      else $error("no-op slot changed accumulator");

   // Strobes are single-clock pulses so the file sees one access each
   read_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_FILE_RE |=> !O_FILE_RE)
      else $error("read strobe longer than one clock");
   write_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_FILE_WE |=> !O_FILE_WE)
      else $error("write strobe longer than one clock");
endmodule : isx_exec

// ---- rtl/isx_pkg.sv ----
// Shared constants for the increment-skip / or-literal execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package isx_pkg;
   // ----------------------------------------
   // Instruction word layout
   // ----------------------------------------
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int CLS_HI = 13;
   localparam int CLS_LO = 12;
   localparam int OP_HI = 11;
   localparam int OP_LO = 8;
   localparam int DEST_BIT = 7;
   localparam logic [1:0] CLS_FILE = 2'h0;
   localparam logic [1:0] CLS_LIT = 2'h3;
   localparam logic [3:0] OP_INC_SKIP = 4'hF;
   localparam logic [3:0] OP_OR_LIT = 4'h8;
   // ----------------------------------------
   // Status and reset values
   // ----------------------------------------
   localparam int ZERO_BIT = 2;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
   // ----------------------------------------
   // Quarter phase sequencer
   // ----------------------------------------
   localparam int PHASES = 4;
   typedef enum logic [3:0] {
      ISX_PH_FIRST = 4'h1,
      ISX_PH_SECOND = 4'h2,
      ISX_PH_THIRD = 4'h4,
      ISX_PH_FOURTH = 4'h8
   } isx_phase_t;
endpackage : isx_pkg

// ---- rtl/isx_phase_gen.sv ----
// Quarter phase sequencer: one instruction cycle is four clocks.
// Assumes a free-running clock; each phase lasts one clock.
`timescale 1ns/10ps
module isx_phase_gen (
   input wire logic i_clk,
   input wire logic i_reset_n,
   output isx_pkg::isx_phase_t o_phase
);
   // ----------------------------------------
   // Phase rotation
   // ----------------------------------------
   isx_pkg::isx_phase_t phase_r;

   // Rotate one-hot phase each clock
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_r <= isx_pkg::ISX_PH_FIRST;
      end else begin
         case (phase_r)
            isx_pkg::ISX_PH_FIRST: phase_r <= isx_pkg::ISX_PH_SECOND;
            isx_pkg::ISX_PH_SECOND: phase_r <= isx_pkg::ISX_PH_THIRD;
            isx_pkg::ISX_PH_THIRD: phase_r <= isx_pkg::ISX_PH_FOURTH;
            isx_pkg::ISX_PH_FOURTH: phase_r <= isx_pkg::ISX_PH_FIRST;
            default: phase_r <= isx_pkg::ISX_PH_FIRST;
         endcase
      end
   end

   assign o_phase = phase_r;
endmodule : isx_phase_gen

// ---- bench/isx_regfile_model.sv ----
// Register file model facing the execute block's read and write strobes.
// Assumes one-clock read latency; address a is preset to hold FF minus a.
`timescale 1ns/10ps
module isx_regfile_model (
   input wire logic i_clk,
   input wire logic i_re,
   input wire logic [6:0] i_addr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_r [0:127];
   // Preset contents
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem_r[i] = 8'hFF - 8'(i);
      end
      o_rdata = 8'hA5;
   end
   // Stale data toggles every clock, so a late sample never looks valid
   always @(posedge i_clk) begin
      o_rdata <= i_re ? mem_r[i_addr] : ~o_rdata;
      if (i_we) begin
         mem_r[i_addr] <= i_wdata;
      end
   end
endmodule : isx_regfile_model

// ---- bench/tb_isx_exec.sv ----
// Self-checking bench for the increment-skip / or-literal block.
// Assumes the register file model above; one instruction per four clocks.
`timescale 1ns/10ps
module tb_isx_exec;
   logic I_CLK, I_RESET_N;
   logic [13:0] I_INSN;
   logic [7:0] rdata, wdata, acc, wdata_q4;
   logic [3:0] phase;
   logic re, we, zero, skip, cend, re_q2, we_q4, cend_q4;
   logic [6:0] addr, addr_q2;
   int fail_count = 0;
   int cmp_count = 0;
   isx_exec DUT (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_INSN(I_INSN), .I_FILE_RDATA(rdata),
      .O_PHASE(phase), .O_FILE_RE(re), .O_FILE_ADDR(addr), .O_FILE_WE(we), .O_FILE_WDATA(wdata),
      .O_ACC(acc), .O_ZERO(zero), .O_SKIP(skip), .O_CYCLE_END(cend));
   isx_regfile_model u_rf (.i_clk(I_CLK), .i_re(re), .i_addr(addr), .i_we(we), .i_wdata(wdata),
      .o_rdata(rdata));
   // ----------------------------------------
   // Clock, compare and closing
   // ----------------------------------------
   initial begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // Issue one word at the first phase; strobes captured in phases two and four.
   // Results of the previous word are settled when this returns.
   task automatic step(input logic [13:0] w);
      do @(posedge I_CLK); while (phase !== 4'h8);
      I_INSN <= w;
      @(posedge I_CLK);
      #1;
      re_q2 = re;
      addr_q2 = addr;
      repeat (2) @(posedge I_CLK);
      #1;
      we_q4 = we;
      wdata_q4 = wdata;
      cend_q4 = cend;
   endtask : step
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_or;
      step(14'h3800);
      step(14'h3835);
      check(acc, 8'h00);
      check(zero, 8'h01);
      step(14'h389A);
      check(acc, 8'h35);
      check(zero, 8'h00);
      step(14'h38FF);
      check(acc, 8'hBF);
      step(14'h0000);
      check(acc, 8'hFF);
      $display("or-literal test done");
   endtask : t_or
   task automatic t_inc;
      step(14'h0F05);
      check(re_q2, 8'h01);
      check(addr_q2, 8'h05);
      check(we_q4, 8'h00);
      check(cend_q4, 8'h01);
      step(14'h0000);
      check(acc, 8'hFB);
      check(skip, 8'h00);
      $display("increment test done");
   endtask : t_inc
   task automatic t_skip;
      step(14'h0F80);
      check(we_q4, 8'h01);
      check(wdata_q4, 8'h00);
      step(14'h3801);
      check(skip, 8'h01);
      check(acc, 8'hFB);
      check(zero, 8'h00);
      step(14'h0F00);
      check(acc, 8'hFB);
      check(skip, 8'h00);
      step(14'h0E05);
      check(acc, 8'h01);
      check(re_q2, 8'h00);
      check(we_q4, 8'h00);
      step(14'h3905);
      step(14'h0000);
      check(acc, 8'h01);
      $display("skip and refusal test done");
   endtask : t_skip
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      I_RESET_N = 1'b0;
      I_INSN = 14'h0000;
      repeat (12) @(posedge I_CLK);
      check(phase, 8'h01);
      check(acc, 8'h00);
      I_RESET_N <= 1'b1;
      t_or();
      t_inc();
      t_skip();
      finish_test();
   end
   // Whole run is well under 100 instruction cycles
   initial begin
      #20000;
      fail_count++;
      $display("FAIL %0t watchdog expired", $time);
      finish_test();
   end
endmodule : tb_isx_exec
